// ---- cdb_divider_bank.sv ----
`timescale 1ns/1ps
module cdb_divider_bank #(
	parameter int CNT_W = 6
)(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic master_reset_output_enable,
	input wire logic prescale_halve_select,
	input wire logic [2:0] feedback_ratio_select,
	input wire logic [1:0] first_bank_ratio_select,
	input wire logic [1:0] second_bank_ratio_select,
	input wire logic [1:0] third_bank_ratio_select,
	input wire logic third_bank_upper_invert,
	input wire logic serial_freeze_clock,
	input wire logic serial_freeze_data,
	output logic [3:0] first_bank_outputs,
	output logic [3:0] second_bank_outputs,
	output logic [3:0] third_bank_outputs,
	output logic loop_feedback_output,
	output logic coincidence_pulse_output,
	output logic outputs_enabled
);
	import cdb_pkg::*;

	if (CNT_W < cdb_pkg::CDB_CNT_W)
	begin : g_bad_width
		$error("CNT_W too small for the longest period.");
	end

	logic rst_all;
	logic [2:0] sel [CDB_NCH];
	logic [CNT_W-1:0] cnt_q [CDB_NCH];
	logic [CNT_W-1:0] cnt_d [CDB_NCH];
	logic [CNT_W-1:0] per_q [CDB_NCH];
	logic [CNT_W-1:0] per_d [CDB_NCH];
	logic [CNT_W-1:0] new_per [CDB_NCH];
	logic [CNT_W-1:0] rem_d [CDB_NCH];
	logic [CDB_NCH-1:0] wrap;
	logic [CDB_NCH-1:0] raw_d;
	logic [CNT_W-1:0] fast_per;
	logic sync_raw_d;
	logic coin_d;
	logic [CDB_FRZ_W-1:0] gate_q;
	logic [CDB_FRZ_W-1:0] gate_d;
	logic [CDB_FRZ_W-1:0] gate_upd;
	logic [CDB_FRZ_W-1:0] freeze_q;
	logic [CDB_FRZ_W-1:0] shift_q;
	logic [3:0] bit_cnt_q;
	cdb_rx_t rx_q;
	logic sclk_s1_q;
	logic sclk_s2_q;
	logic sclk_s3_q;
	logic serial_freeze_data_s1_q;
	logic serial_freeze_data_s2_q;
	logic sclk_rise;
	logic frame_done;

	assign rst_all = rst | ~master_reset_output_enable; // RULE_19

	assign sel[CDB_CH_A] = {1'b0, first_bank_ratio_select};
	assign sel[CDB_CH_B] = {1'b0, second_bank_ratio_select};
	assign sel[CDB_CH_C] = {1'b0, third_bank_ratio_select};
	assign sel[CDB_CH_FB] = feedback_ratio_select;

	// One counter per divider; a new period is taken only at the wrap, so each
	// emitted period is wholly the old one or wholly the new one.
	for (genvar ch = 0; ch < CDB_NCH; ch++)
	begin : g_ch
		assign new_per[ch] = prescale_halve_select ? CNT_W'(CDB_PER_TBL[ch][sel[ch]]) // RULE_02
			: CNT_W'({CDB_PER_TBL[ch][sel[ch]], 1'b0}); // RULE_03 RULE_04
		assign wrap[ch] = cnt_q[ch] == per_q[ch] - 1'b1;
		assign cnt_d[ch] = wrap[ch] ? '0 : cnt_q[ch] + 1'b1; // RULE_01
		assign per_d[ch] = wrap[ch] ? new_per[ch] : per_q[ch]; // RULE_06
		assign raw_d[ch] = cnt_d[ch] < (per_d[ch] >> 1);
		assign rem_d[ch] = per_d[ch] - cnt_d[ch];

		always_ff @(posedge clk_sys)
		begin
			if (rst_all)
			begin
				cnt_q[ch] <= '0;
				per_q[ch] <= CNT_W'(CDB_PER_RST);
			end
			else
			begin
				cnt_q[ch] <= cnt_d[ch];
				per_q[ch] <= per_d[ch];
			end
		end
	end

	// Equal distances to the next rise mean the next A and C rises coincide.
	assign fast_per = (per_d[CDB_CH_A] < per_d[CDB_CH_C]) ? per_d[CDB_CH_A] : per_d[CDB_CH_C]; // RULE_08
	assign sync_raw_d = ~((rem_d[CDB_CH_A] == rem_d[CDB_CH_C]) && (rem_d[CDB_CH_A] <= fast_per)); // RULE_07 RULE_09
	assign coin_d = wrap[CDB_CH_A] & wrap[CDB_CH_C]; // RULE_20

	// Enables move only at a rising boundary of their own output (a falling one on the inverted upper C pair), which avoids runts.
	for (genvar i = 0; i < CDB_FRZ_W; i++)
	begin : g_gate
		localparam int CH = (i < CDB_FRZ_B_LSB) ? CDB_CH_A : (i < CDB_FRZ_C_LSB) ? CDB_CH_B : CDB_CH_C; // RULE_18
		assign gate_upd[i] = (i == CDB_FRZ_SYNC) ? coin_d : wrap[CH]; // RULE_14
	end
	assign gate_d = (gate_upd & freeze_q) | (~gate_upd & gate_q);

	always_ff @(posedge clk_sys)
	begin
		if (rst_all)
			gate_q <= CDB_FRZ_RST;
		else
			gate_q <= gate_d;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst_all)
		begin
			first_bank_outputs <= '0; // RULE_19
			second_bank_outputs <= '0;
			third_bank_outputs <= '0;
			loop_feedback_output <= 1'b0;
			coincidence_pulse_output <= 1'b0;
			outputs_enabled <= 1'b0;
		end
		else
		begin
			first_bank_outputs <= {4{raw_d[CDB_CH_A]}} & gate_d[CDB_FRZ_B_LSB-1:CDB_FRZ_A_LSB]; // RULE_10 RULE_13
			second_bank_outputs <= {4{raw_d[CDB_CH_B]}} & gate_d[CDB_FRZ_C_LSB-1:CDB_FRZ_B_LSB];
			third_bank_outputs <= {{2{raw_d[CDB_CH_C] ^ third_bank_upper_invert}} // RULE_05
				& gate_d[CDB_FRZ_SYNC-1:CDB_FRZ_C_LSB+1], raw_d[CDB_CH_C] & gate_d[CDB_FRZ_C_LSB],
				raw_d[CDB_CH_C]}; // RULE_12
			loop_feedback_output <= raw_d[CDB_CH_FB]; // RULE_12
			coincidence_pulse_output <= sync_raw_d & gate_d[CDB_FRZ_SYNC];
			outputs_enabled <= 1'b1;
		end
	end

	// The serial clock is only sampled, so it must run well below clk_sys.
	always_ff @(posedge clk_sys)
	begin
		if (rst_all)
		begin
			sclk_s1_q <= 1'b0;
			sclk_s2_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			serial_freeze_data_s1_q <= 1'b1;
			serial_freeze_data_s2_q <= 1'b1;
		end
		else
		begin
			sclk_s1_q <= serial_freeze_clock;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			serial_freeze_data_s1_q <= serial_freeze_data;
			serial_freeze_data_s2_q <= serial_freeze_data_s1_q;
		end
	end

	assign sclk_rise = sclk_s2_q & ~sclk_s3_q; // RULE_17
	assign frame_done = (rx_q == CDB_RX_SHIFT) && sclk_rise && (bit_cnt_q == CDB_LAST_BIT);

	always_ff @(posedge clk_sys)
	begin
		if (rst_all)
		begin
			rx_q <= CDB_RX_IDLE;
			bit_cnt_q <= '0;
			shift_q <= '0;
		end
		else
		begin
			case (rx_q)
				CDB_RX_IDLE:
				begin
					if (sclk_rise && (serial_freeze_data_s2_q == CDB_START_BIT)) // RULE_15
					begin
						rx_q <= CDB_RX_SHIFT;
						bit_cnt_q <= '0;
					end
				end
				CDB_RX_SHIFT:
				begin
					if (sclk_rise)
					begin
						shift_q <= {serial_freeze_data_s2_q, shift_q[CDB_FRZ_W-1:1]}; // RULE_21
						bit_cnt_q <= bit_cnt_q + 1'b1;
						if (bit_cnt_q == CDB_LAST_BIT)
							rx_q <= CDB_RX_IDLE;
					end
				end
				default:
					rx_q <= CDB_RX_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst_all)
			freeze_q <= CDB_FRZ_RST;
		else if (frame_done)
			freeze_q <= {serial_freeze_data_s2_q, shift_q[CDB_FRZ_W-1:1]}; // RULE_11 RULE_22
	end

	sequence last_bit_s;
		rx_q == CDB_RX_SHIFT && sclk_rise && bit_cnt_q == CDB_LAST_BIT;
	endsequence

	sequence start_bit_s;
		rx_q == CDB_RX_IDLE && sclk_rise && !serial_freeze_data_s2_q;
	endsequence

	reset_quiet_a: assert property (@(posedge clk_sys) rst_all |=> // RULE_19
		first_bank_outputs == '0 && third_bank_outputs == '0 && !loop_feedback_output && !outputs_enabled)
		else $error("Outputs active after master reset.");

	frame_start_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_15
		start_bit_s |=> rx_q == CDB_RX_SHIFT && bit_cnt_q == '0)
		else $error("Start bit not taken.");

	frame_end_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_22
		last_bit_s |=> rx_q == CDB_RX_IDLE && freeze_q == {$past(serial_freeze_data_s2_q), $past(shift_q[CDB_FRZ_W-1:1])})
		else $error("Freeze word not applied at frame end.");

	freeze_hold_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_22
		!frame_done |=> $stable(freeze_q))
		else $error("Freeze word changed mid frame.");

	period_change_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_06
		!wrap[CDB_CH_A] |=> $stable(per_q[CDB_CH_A]))
		else $error("Bank A period changed mid period.");

	frozen_low_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_10
		!gate_q[CDB_FRZ_A_LSB] |-> !first_bank_outputs[0])
		else $error("Frozen output is not low.");

	c_zero_runs_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_12
		outputs_enabled |-> third_bank_outputs[0] == (cnt_q[CDB_CH_C] < (per_q[CDB_CH_C] >> 1)))
		else $error("First bank C output does not follow its divider.");

	sync_align_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_20
		$rose(coincidence_pulse_output) |-> cnt_q[CDB_CH_A] == '0 && cnt_q[CDB_CH_C] == '0)
		else $error("Coincidence pulse rise not aligned with banks A and C.");

	gate_edge_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_14
		$changed(gate_q[CDB_FRZ_A_LSB]) |-> cnt_q[CDB_CH_A] == '0)
		else $error("Bank A enable moved off a period boundary.");

	b_frozen_low_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_10
		!gate_q[CDB_FRZ_B_LSB] |-> !second_bank_outputs[0])
		else $error("Frozen bank B output is not low.");

	c_frozen_low_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_10
		!gate_q[CDB_FRZ_C_LSB] |-> !third_bank_outputs[1])
		else $error("Frozen bank C output is not low.");

	pulse_frozen_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_18
		!gate_q[CDB_FRZ_SYNC] |-> !coincidence_pulse_output)
		else $error("Frozen coincidence pulse is not low.");

	fb_runs_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_12
		outputs_enabled |-> loop_feedback_output == (cnt_q[CDB_CH_FB] < (per_q[CDB_CH_FB] >> 1)))
		else $error("Feedback output does not follow its divider.");

	invert_pair_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_05
		outputs_enabled && (&gate_q[CDB_FRZ_SYNC-1:CDB_FRZ_C_LSB]) |->
		third_bank_outputs[3:2] == {2{third_bank_outputs[1] ^ $past(third_bank_upper_invert)}})
		else $error("Upper bank C pair not inverted as selected.");

	b_period_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_06
		!wrap[CDB_CH_B] |=> $stable(per_q[CDB_CH_B]))
		else $error("Bank B period changed mid period.");

	c_period_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_06
		!wrap[CDB_CH_C] |=> $stable(per_q[CDB_CH_C]))
		else $error("Bank C period changed mid period.");

	b_gate_edge_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_14
		$changed(gate_q[CDB_FRZ_B_LSB]) |-> cnt_q[CDB_CH_B] == '0)
		else $error("Bank B enable moved off a period boundary.");

	c_gate_edge_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_14
		$changed(gate_q[CDB_FRZ_C_LSB]) |-> cnt_q[CDB_CH_C] == '0)
		else $error("Bank C enable moved off a period boundary.");

	pulse_gate_edge_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_14
		$changed(gate_q[CDB_FRZ_SYNC]) |-> cnt_q[CDB_CH_A] == '0 && cnt_q[CDB_CH_C] == '0)
		else $error("Pulse enable moved off a coincidence.");

	gate_follow_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_22
		frame_done |-> ##[1:26] gate_q[CDB_FRZ_A_LSB] == freeze_q[CDB_FRZ_A_LSB])
		else $error("Bank A enable did not take the new freeze word.");

	bit_count_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_11
		rx_q == CDB_RX_SHIFT |-> bit_cnt_q <= CDB_LAST_BIT)
		else $error("Frame bit count ran past twelve bits.");

	idle_high_a: assert property (@(posedge clk_sys) disable iff (rst_all) // RULE_21
		rx_q == CDB_RX_IDLE && sclk_rise && serial_freeze_data_s2_q |=> rx_q == CDB_RX_IDLE)
		else $error("Idle high line started a frame.");

	enable_after_a: assert property (@(posedge clk_sys) // RULE_19
		!rst_all |=> outputs_enabled)
		else $error("Outputs not enabled after reset release.");

endmodule // cdb_divider_bank

// ---- cdb_divider_bank_bench.sv ----
`timescale 1ns/1ps
module cdb_divider_bank_bench;
	logic clk_sys = 1'b0, rst = 1'b1, mr_n = 1'b1, pre = 1'b1, inv = 1'b0;
	logic [2:0] fbs = 3'h0;
	logic [1:0] sel = 2'h0;
	logic sclk, sdat, en, sync, fb, ps, gl = 1'b0, sk = 1'b0;
	logic [3:0] qa, qb, qc;
	logic [2:0] prv = 3'h0, cur;
	int cnt[3], per[3], eo[3], ex[3], lo, cyc, fails, n_checks;
	cdb_divider_bank u_cdb_divider_bank (.clk_sys(clk_sys), .rst(rst), .master_reset_output_enable(mr_n),
		.prescale_halve_select(pre), .feedback_ratio_select(fbs), .first_bank_ratio_select(sel),
		.second_bank_ratio_select(sel), .third_bank_ratio_select(sel), .third_bank_upper_invert(inv),
		.serial_freeze_clock(sclk), .serial_freeze_data(sdat), .first_bank_outputs(qa),
		.second_bank_outputs(qb), .third_bank_outputs(qc), .loop_feedback_output(fb),
		.coincidence_pulse_output(sync), .outputs_enabled(en));
	cdb_freeze_ctrl u_cdb_freeze_ctrl (.serial_freeze_clock(sclk), .serial_freeze_data(sdat));
	initial
	begin
		forever #20 clk_sys = ~clk_sys;
	end
	task automatic chk_v(string s, logic [3:0] e, logic [3:0] g);
		n_checks++;
		if (e !== g)
		begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task automatic chk_n(string s, int e, int g);
		n_checks++;
		if (e != g)
		begin
			fails++;
			$display("unexpected %s: expected %0d, seen %0d", s, e, g);
		end
	endtask
	function automatic int ep(int b, int k);
		int t[3][4] = '{'{4, 6, 8, 12}, '{4, 6, 8, 10}, '{2, 4, 6, 8}};
		return t[b][k] * (pre ? 1 : 2);
	endfunction
	// Periods are measured on output 0 of each bank; a period off both old and new is a glitch.
	always @(negedge clk_sys)
	begin
		cur = {qc[0], qb[0], qa[0]};
		for (int i = 0; i < 3; i++)
		begin
			cnt[i]++;
			if (cur[i] && !prv[i])
			begin
				per[i] = cnt[i];
				cnt[i] = 0;
				if (gl && per[i] != eo[i])
					chk_n("changed period", ex[i], per[i]);
			end
		end
		if (gl && sync && !ps)
		begin
			chk_v("rises at pulse", 4'h3, {2'h0, cur[2] & !prv[2], cur[0] & !prv[0]});
			if (sk)
				chk_n("pulse length", ex[2], lo);
		end
		lo = sync ? 0 : lo + 1;
		ps = sync;
		prv = cur;
	end
	task automatic reset_for(logic use_mr, int n);
		rst = !use_mr;
		mr_n = !use_mr;
		repeat (n) @(negedge clk_sys);
		chk_v("outputs in reset", 4'h0, {en, qa[0], qc[0], fb});
		rst = 1'b0;
		mr_n = 1'b1;
		@(negedge clk_sys);
		chk_v("enable", 4'h1, {3'h0, en});
	endtask
	task automatic frz(logic [11:0] w, logic [3:0] ea, logic [3:0] ec, logic [3:0] es);
		logic [3:0] oa, ob, oc, os;
		u_cdb_freeze_ctrl.send(w);
		repeat (100) @(negedge clk_sys);
		{oa, ob, oc, os} = 16'h0000;
		repeat (100)
		begin
			@(negedge clk_sys);
			{oa, ob, oc, os} |= {qa, qb, qc, 2'h0, fb, sync};
		end
		chk_v("bank a running", ea, oa);
		chk_v("bank b running", ea, ob);
		chk_v("bank c running", ec, oc);
		chk_v("pulse and feedback", es, os);
		$display("freeze test done");
	endtask
	initial
	begin
		reset_for(1'b0, 5);
		repeat (20) @(negedge clk_sys);
		frz(12'h6ee, 4'he, 4'hd, 4'h2);
		frz(12'hfff, 4'hf, 4'hf, 4'h3);
		for (int i = 0; i < 3; i++)
			ex[i] = ep(i, 0);
		for (int j = 1; j >= 0; j--)
			for (int k = 0; k < 4; k++)
			begin
				sk = 1'b0;
				@(negedge clk_sys);
				pre = j[0];
				sel = k[1:0];
				gl = 1'b1;
				for (int i = 0; i < 3; i++)
				begin
					eo[i] = ex[i];
					ex[i] = ep(i, k);
				end
				repeat (120) @(negedge clk_sys);
				sk = 1'b1;
				repeat (120) @(negedge clk_sys);
				for (int i = 0; i < 3; i++)
					chk_n("bank period", ex[i], per[i]);
			end
		$display("ratio test done");
		for (int v = 0; v < 2; v++)
		begin
			inv = v[0];
			repeat (16)
			begin
				@(negedge clk_sys);
				chk_v("upper c pair", {2'h0, {2{qc[1] ^ inv}}}, {2'h0, qc[3:2]});
			end
		end
		$display("invert test done");
		gl = 1'b0;
		reset_for(1'b1, 3);
		$display("reset test done");
		end_of_test();
	end
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			fails++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
endmodule // cdb_divider_bank_bench

// ---- cdb_freeze_ctrl.sv ----
`timescale 1ns/1ps
module cdb_freeze_ctrl (
	output logic serial_freeze_clock,
	output logic serial_freeze_data
);
	// The serial clock runs free; data moves on its falling edge so it is settled at each rise.
	initial
	begin
		serial_freeze_clock = 1'b0;
		serial_freeze_data = 1'b1;
		forever #160 serial_freeze_clock = ~serial_freeze_clock;
	end
	task automatic send(input logic [11:0] w);
		@(negedge serial_freeze_clock);
		serial_freeze_data = 1'b0;
		for (int i = 0; i < 12; i++)
		begin
			@(negedge serial_freeze_clock);
			serial_freeze_data = w[i];
		end
		@(negedge serial_freeze_clock);
		serial_freeze_data = 1'b1;
	endtask
endmodule // cdb_freeze_ctrl

// ---- cdb_pkg.sv ----
// Function
// RULE_01: Every bank output divides the oscillator clock.
// RULE_02: Prescale select low halves oscillator first.
// RULE_03: Banks A and B follow their ratio tables.
// RULE_04: Bank C follows its own ratio table.
// RULE_05: Invert input flips third and fourth C outputs.
// RULE_06: Ratio changes never yield runt or stretched periods.
// RULE_07: Coincidence pulse low one period before alignment.
// RULE_08: Pulse period is the faster bank's period.
// RULE_09: Pulse works for every ratio combination; with equal A and C periods the code holds it at a constant level.
// RULE_10: Frozen outputs stop at logic zero.
// RULE_11: Freeze register holds twelve enable bits.
// RULE_12: First C output and feedback never freeze.
// RULE_13: Bit zero freezes, bit one enables.
// RULE_14: Freeze changes apply only at clean boundaries.
// RULE_15: Controller sends zero start bit, twelve bits.
// RULE_16: Controller holds each bit one serial clock.
// RULE_17: Serial data sampled on serial clock rise.
// RULE_18: Bit groups map to banks A, B, C, pulse.
// RULE_19: Master reset low clears state, disables outputs.
// RULE_20: Pulse rising edge aligns with A and C rising.
// RULE_21: Bit zero first, bit eleven last, idle high.
// RULE_22: New freeze settings apply after complete frame.
package cdb_pkg;
	localparam int CDB_NCH = 4;
	localparam int CDB_CH_A = 0;
	localparam int CDB_CH_B = 1;
	localparam int CDB_CH_C = 2;
	localparam int CDB_CH_FB = 3;
	localparam int CDB_CNT_W = 6;
	// Periods in oscillator cycles with the prescale bypassed; halving doubles them.
	localparam logic [5:0] CDB_PER_TBL [CDB_NCH][8] = '{
		'{6'h04, 6'h06, 6'h08, 6'h0c, 6'h04, 6'h06, 6'h08, 6'h0c},
		'{6'h04, 6'h06, 6'h08, 6'h0a, 6'h04, 6'h06, 6'h08, 6'h0a},
		'{6'h02, 6'h04, 6'h06, 6'h08, 6'h02, 6'h04, 6'h06, 6'h08},
		'{6'h04, 6'h06, 6'h08, 6'h0a, 6'h08, 6'h0c, 6'h10, 6'h14}};
	localparam logic [5:0] CDB_PER_RST = 6'h04;
	localparam int CDB_FRZ_W = 12;
	localparam int CDB_FRZ_A_LSB = 0;
	localparam int CDB_FRZ_B_LSB = 4;
	localparam int CDB_FRZ_C_LSB = 8;
	localparam int CDB_FRZ_SYNC = 11;
	localparam logic [11:0] CDB_FRZ_RST = 12'hfff;
	localparam logic [3:0] CDB_LAST_BIT = 4'hb;
	localparam logic CDB_START_BIT = 1'b0;
	typedef enum logic {CDB_RX_IDLE, CDB_RX_SHIFT} cdb_rx_t;
endpackage
